// ### design/dcsp_chained_serial_port.sv
// dcsp_chained_serial_port: receive, forward and transmit logic of the chained serial port
// assumes: serial_clock runs free; serial_in changes away from both of its edges;
// register contents and display memory live outside, fed by the write strobes below
`include "dcsp_params.svh"
`timescale 1ns/1ps
`default_nettype none

module dcsp_chained_serial_port (
   input wire logic clock,
   input wire logic rstn,
   input wire logic serial_clock,
   input wire logic serial_in,
   output logic serial_out,
   input wire logic undervoltage_flag,
   input wire logic thermal_entry,
   input wire logic ref_short_entry,
   input wire logic [47:0] read_data,
   output logic cfg_write_valid,
   output dcsp_pkg::dcsp_frame_t cfg_write,
   output logic display_write_valid,
   output dcsp_pkg::dcsp_frame_t display_write,
   output logic frame_sync,
   output logic soft_reset,
   output logic [4:0] chip_addr,
   output logic [4:0] chip_count_m1,
   output logic power_save,
   output logic channels_off
);

   localparam dcsp_pkg::dcsp_link_t LINK_IDLE = '{
      hist: '1, mode: dcsp_pkg::DCSP_OUT_PASS, pc: 7'h7f, ob: 1'b1, default: '0};

   // ----------------------------------------------------------------------
   // one bit through the receive and forward path
   // ----------------------------------------------------------------------
   function automatic dcsp_pkg::dcsp_link_t link_step(
      input dcsp_pkg::dcsp_link_t s,
      input logic b,
      input logic [47:0] rd
   );
      dcsp_pkg::dcsp_link_t n;
      logic [15:0] nid;
      logic [`DCSP_PAY_BITS-1:0] w;
      logic is_idx;
      logic is_rd;
      n = s;
      nid = 16'h0000;
      w = '0;
      is_idx = 1'b0;
      is_rd = 1'b0;
      n.done = 1'b0;
      n.hist = {s.hist[`DCSP_HIST_BITS-2:0], b};
      if (s.mode == dcsp_pkg::DCSP_OUT_INS && s.pc >= 7'd51 && s.pc < 7'd102) begin
         n.ins = {s.ins[`DCSP_PAY_BITS-2:0], 1'b0};
      end
      n.pc = (s.pc == 7'h7f) ? s.pc : s.pc + 7'h01;
      if (!s.in_frame) begin
         if (!b) begin
            n.in_frame = 1'b1;
            n.ones = 5'h00;
            n.bitcnt = 7'h00;
            n.pos = 5'h00;
            n.err = 1'b0;
            n.pend = 1'b0;
         end
      end else begin
         n.bitcnt = (s.bitcnt == 7'h7f) ? s.bitcnt : s.bitcnt + 7'h01;
         n.ones = b ? ((s.ones == 5'h1f) ? s.ones : s.ones + 5'h01) : 5'h00;
         n.pos = (s.pos == 5'd16) ? 5'h00 : s.pos + 5'h01;
         // check bit: a 1-1 failure may be the end run, so hold it pending
         if (s.pos == 5'd16 && b == s.hist[0]) begin
            if (b) n.pend = 1'b1;
            else n.err = 1'b1;
         end
         if (!b && s.pend) begin
            n.err = 1'b1;
            n.pend = 1'b0;
         end
         // header complete: capture identifier, patch chip index on the fly
         if (s.bitcnt == 7'd16) begin
            n.id = n.hist[16:1];
            if (n.hist[16:9] == `DCSP_ID_PREFIX && n.hist[8:1] >= `DCSP_ID_IDX_LO &&
                n.hist[8:1] <= `DCSP_ID_IDX_HI) begin
               nid = n.hist[16:1] + 16'h0001;
               n.hist[16:0] = {nid, ~nid[0]};
            end
         end
         // end is taken on a word-aligned run so a trailing 1 check bit
         // does not shift the payload window by one
         if (n.ones >= 5'd18 && n.pos == 5'd1) begin
            n.in_frame = 1'b0;
            w = n.hist[`DCSP_HIST_BITS-1:`DCSP_END_ONES];
            is_idx = n.id[15:8] == `DCSP_ID_PREFIX && n.id[7:0] >= `DCSP_ID_IDX_LO &&
                     n.id[7:0] <= `DCSP_ID_IDX_HI;
            is_rd = n.id[15:8] == `DCSP_ID_PREFIX && n.id[7:5] == `DCSP_ID_RD_TOP;
            n.done = !n.err && s.bitcnt >= 7'd16;
            n.frm.id = is_idx ? n.id : n.id;
            n.frm.data = {w[50:35], w[33:18], w[16:1]};
            n.pc = 7'h00;
            n.ins = {rd[47:32], ~rd[32], rd[31:16], ~rd[16], rd[15:0], ~rd[0]};
            if (n.id == `DCSP_ID_GRAY_WR && n.bitcnt >= `DCSP_MIN_PAY_FRAME) begin
               n.mode = dcsp_pkg::DCSP_OUT_CUT;
            end else if (is_rd) begin
               n.mode = dcsp_pkg::DCSP_OUT_INS;
            end else begin
               n.mode = dcsp_pkg::DCSP_OUT_PASS;
            end
         end
      end
      // forward tap sits a full payload plus end run behind the input
      unique case (n.mode)
         dcsp_pkg::DCSP_OUT_CUT: n.ob = (n.pc < 7'd51) ? 1'b1 : n.hist[`DCSP_HIST_BITS-1];
         dcsp_pkg::DCSP_OUT_INS: n.ob = (n.pc >= 7'd51 && n.pc < 7'd102) ?
                                        n.ins[`DCSP_PAY_BITS-1] : n.hist[`DCSP_HIST_BITS-1];
         dcsp_pkg::DCSP_OUT_PASS: n.ob = n.hist[`DCSP_HIST_BITS-1];
         default: n.ob = n.hist[`DCSP_HIST_BITS-1];
      endcase
      return n;
   endfunction

   // ----------------------------------------------------------------------
   // link clock domain
   // ----------------------------------------------------------------------
   logic [1:0] lrst_q;
   logic lrst_n;
   logic [1:0] luv_q;
   logic neg_bit_q;
   dcsp_pkg::dcsp_link_t st_q;
   dcsp_pkg::dcsp_link_t st_a;
   dcsp_pkg::dcsp_link_t st_b;
   logic ob2_q;
   logic out_p_q;
   logic out_n_q;
   dcsp_pkg::dcsp_frame_t evt_q;
   logic evt_tgl_q;
   logic [2:0] rreq_q;
   logic rack_q;
   logic [47:0] rd_link_q;
   logic rd_req_q;
   logic [47:0] rd_snap_q;

   // reset release retimed onto the link clock
   always_ff @(posedge serial_clock or negedge rstn) begin
      if (!rstn) begin
         lrst_q <= 2'h0;
      end else begin
         lrst_q <= {lrst_q[0], 1'b1};
      end
   end
   assign lrst_n = lrst_q[1];

   // undervoltage level into the link domain
   always_ff @(posedge serial_clock or negedge lrst_n) begin
      if (!lrst_n) begin
         luv_q <= 2'h0;
      end else begin
         luv_q <= {luv_q[0], undervoltage_flag};
      end
   end

   // falling edge half of the dual-edge sampler; older bit of each pair
   always_ff @(negedge serial_clock or negedge lrst_n) begin
      if (!lrst_n) begin
         neg_bit_q <= 1'b1;
      end else begin
         neg_bit_q <= serial_in;
      end
   end

   // two bits per rising edge: falling-edge bit first, then rising-edge bit
   always_comb begin
      st_a = link_step(st_q, neg_bit_q, rd_link_q);
      st_b = link_step(st_a, serial_in, rd_link_q);
   end

   always_ff @(posedge serial_clock or negedge lrst_n) begin
      if (!lrst_n) begin
         st_q <= LINK_IDLE;
      end else if (luv_q[1]) begin
         st_q <= LINK_IDLE;
      end else begin
         st_q <= st_b;
      end
   end

   // dual-edge output: xor pair keeps each half glitch free
   always_ff @(posedge serial_clock or negedge lrst_n) begin
      if (!lrst_n) begin
         out_p_q <= 1'b1;
         ob2_q <= 1'b1;
      end else begin
         out_p_q <= st_a.ob ^ out_n_q;
         ob2_q <= st_b.ob;
      end
   end

   always_ff @(negedge serial_clock or negedge lrst_n) begin
      if (!lrst_n) begin
         out_n_q <= 1'b0;
      end else begin
         out_n_q <= ob2_q ^ out_p_q;
      end
   end
   assign serial_out = out_p_q ^ out_n_q;

   // accepted frame held stable, announced by a toggle
   always_ff @(posedge serial_clock or negedge lrst_n) begin
      if (!lrst_n) begin
         evt_q <= '0;
         evt_tgl_q <= 1'b0;
      end else if (st_a.done || st_b.done) begin
         evt_q <= st_a.done ? st_a.frm : st_b.frm;
         evt_tgl_q <= ~evt_tgl_q;
      end
   end

   // read data snapshot taken from the system side by request toggle
   always_ff @(posedge serial_clock or negedge lrst_n) begin
      if (!lrst_n) begin
         rreq_q <= 3'h0;
         rack_q <= 1'b0;
         rd_link_q <= 48'h0000_0000_0000;
      end else begin
         rreq_q <= {rreq_q[1:0], rd_req_q};
         if (rreq_q[2] != rreq_q[1]) begin
            rd_link_q <= rd_snap_q;
            rack_q <= rreq_q[1];
         end
      end
   end

   // ----------------------------------------------------------------------
   // system clock domain
   // ----------------------------------------------------------------------
   logic [2:0] flg_m_q;
   logic [2:0] flg_q;
   logic [2:0] evt_s_q;
   logic [1:0] rack_s_q;
   logic evt_new;
   logic init;
   logic is_bcast;
   logic is_srst;
   logic is_fsync;
   logic is_idx_evt;
   logic is_read;
   logic [5:0] hops;
   logic [9:0] dly_q;
   logic dly_run_q;
   logic fs_now;
   logic nz_q;
   logic ps_q;
   logic ps_en_q;
   logic [4:0] chip_num_q;
   logic [4:0] addr_q;

   // pin-level protection flags: undervoltage, thermal, reference short
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         flg_m_q <= 3'h0;
         flg_q <= 3'h0;
      end else begin
         flg_m_q <= {undervoltage_flag, thermal_entry, ref_short_entry};
         flg_q <= flg_m_q;
      end
   end
   assign init = flg_q[2];

   // frame toggle into this domain; the held word is stable by then
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         evt_s_q <= 3'h0;
      end else begin
         evt_s_q <= {evt_s_q[1:0], evt_tgl_q};
      end
   end
   assign evt_new = evt_s_q[2] != evt_s_q[1];

   // identifier decode alone picks broadcast or individual handling
   always_comb begin
      is_srst = evt_q.id == `DCSP_ID_SRST;
      is_fsync = evt_q.id == `DCSP_ID_FSYNC;
      is_idx_evt = evt_q.id[15:8] == `DCSP_ID_PREFIX && evt_q.id[7:0] >= `DCSP_ID_IDX_LO &&
                   evt_q.id[7:0] <= `DCSP_ID_IDX_HI;
      is_read = evt_q.id[15:8] == `DCSP_ID_PREFIX && evt_q.id[7:5] == `DCSP_ID_RD_TOP;
      is_bcast = evt_q.id != `DCSP_ID_GRAY_WR && !is_srst && !is_fsync && !is_idx_evt &&
                 !is_read;
   end

   // read data offered to the link side, refreshed after each acknowledge
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rack_s_q <= 2'h0;
         rd_req_q <= 1'b0;
         rd_snap_q <= 48'h0000_0000_0000;
      end else begin
         rack_s_q <= {rack_s_q[0], rack_q};
         if (rack_s_q[1] == rd_req_q) begin
            rd_snap_q <= read_data;
            rd_req_q <= ~rd_req_q;
         end
      end
   end

   // function registers: address, chain length, power save enable
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         chip_num_q <= `DCSP_CHIP_NUM_RST;
         ps_en_q <= `DCSP_PS_EN_RST;
         addr_q <= 5'h00;
      end else if (init || (evt_new && is_srst)) begin
         chip_num_q <= `DCSP_CHIP_NUM_RST;
         ps_en_q <= `DCSP_PS_EN_RST;
         addr_q <= 5'h00;
      end else if (evt_new) begin
         if (is_idx_evt) begin
            addr_q <= 5'(evt_q.id[7:0] - `DCSP_ID_IDX_LO);
         end
         if (evt_q.id == `DCSP_ID_FC0_WR) begin
            chip_num_q <= evt_q.data[`DCSP_CHIP_NUM_MSB:0];
            ps_en_q <= evt_q.data[`DCSP_PS_EN_BIT];
         end
      end
   end

   // hops still to travel: device count minus own address, at least one
   always_comb begin
      hops = ({1'b0, chip_num_q} + 6'h01) - {1'b0, addr_q};
      if (hops == 6'h00 || hops[5]) begin
         hops = 6'h01;
      end
   end

   // frame sync held back so every device in the chain fires together
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         dly_q <= 10'h000;
         dly_run_q <= 1'b0;
      end else if (init) begin
         dly_q <= 10'h000;
         dly_run_q <= 1'b0;
      end else if (evt_new && is_fsync) begin
         dly_q <= 10'(hops * `DCSP_HOP_CYC);
         dly_run_q <= 1'b1;
      end else if (dly_run_q) begin
         dly_q <= dly_q - 10'h001;
         dly_run_q <= dly_q != 10'h001;
      end
   end
   assign fs_now = dly_run_q && dly_q == 10'h001;

   // power save: zero frames enter at sync, any non-zero display write data leaves at once
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         nz_q <= 1'b0;
         ps_q <= 1'b0;
      end else if (init) begin
         nz_q <= 1'b0;
         ps_q <= 1'b0;
      end else if (evt_new && evt_q.id == `DCSP_ID_GRAY_WR && evt_q.data != 48'h0) begin
         nz_q <= 1'b1; // set wins over the clear at sync
         ps_q <= 1'b0;
      end else if (fs_now) begin
         ps_q <= ps_en_q && !nz_q;
         nz_q <= 1'b0;
      end
   end

   // write strobes and command pulses toward the register and memory blocks
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cfg_write_valid <= 1'b0;
         display_write_valid <= 1'b0;
         cfg_write <= '0;
         display_write <= '0;
         frame_sync <= 1'b0;
         soft_reset <= 1'b0;
      end else begin
         cfg_write_valid <= evt_new && !init && is_bcast;
         display_write_valid <= evt_new && !init && evt_q.id == `DCSP_ID_GRAY_WR;
         if (evt_new && is_bcast) cfg_write <= evt_q;
         if (evt_new && evt_q.id == `DCSP_ID_GRAY_WR) display_write <= evt_q;
         frame_sync <= fs_now && !init;
         soft_reset <= evt_new && is_srst && !init;
      end
   end

   // status outputs; protection and power save gate every channel
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         power_save <= 1'b0;
         channels_off <= 1'b1;
      end else begin
         power_save <= ps_q;
         channels_off <= ps_q || flg_q[1] || flg_q[0] || init;
      end
   end
   assign chip_addr = addr_q;
   assign chip_count_m1 = chip_num_q;

endmodule

`default_nettype wire

// ### design/dcsp_params.svh
// dcsp_params.svh: command codes, frame sizes, field positions, reset values, timing
// assumes: plain text include, pulled in by the package and by the port module
`ifndef DCSP_PARAMS_SVH
`define DCSP_PARAMS_SVH

// ----------------------------------------------------------------------
// frame geometry, in bits
// ----------------------------------------------------------------------
`define DCSP_HDR_BITS 17
`define DCSP_WORD_LAST 16
`define DCSP_PAY_BITS 51
`define DCSP_END_ONES 18
`define DCSP_HIST_BITS 69
`define DCSP_MIN_PAY_FRAME 86

// ----------------------------------------------------------------------
// command identifiers
// ----------------------------------------------------------------------
`define DCSP_ID_PREFIX 8'haa
`define DCSP_ID_FC0_WR 16'haa00
`define DCSP_ID_GRAY_WR 16'haa30
`define DCSP_ID_FSYNC 16'haaf0
`define DCSP_ID_SRST 16'haa80
`define DCSP_ID_IDX_LO 8'h10
`define DCSP_ID_IDX_HI 8'h2f
`define DCSP_ID_RD_TOP 3'h3

// ----------------------------------------------------------------------
// configuration word fields and reset values
// ----------------------------------------------------------------------
`define DCSP_CHIP_NUM_MSB 4
`define DCSP_PS_EN_BIT 12
`define DCSP_CHIP_NUM_RST 5'h07
`define DCSP_PS_EN_RST 1'h0

// ----------------------------------------------------------------------
// timing: one chain hop, turned into system clock cycles (rounded up)
// ----------------------------------------------------------------------
`define DCSP_HOP_NS 207
`define DCSP_SYS_MHZ 20
`define DCSP_HOP_CYC ((`DCSP_HOP_NS * `DCSP_SYS_MHZ + 999) / 1000)

`endif

// ### design/dcsp_pkg.sv
// dcsp_pkg: types shared by the chained serial port and its bench
// assumes: dcsp_params.svh sits beside this file
`include "dcsp_params.svh"

package dcsp_pkg;

   // what the forwarding path does with bits after an end condition
   typedef enum logic [1:0] {
      DCSP_OUT_PASS = 2'b00,
      DCSP_OUT_CUT = 2'b01,
      DCSP_OUT_INS = 2'b10
   } dcsp_out_mode_t;

   // one accepted frame: command identifier and its 48 data bits
   typedef struct packed {
      logic [15:0] id;
      logic [47:0] data;
   } dcsp_frame_t;

   // link-side receive and forward state, stepped once per bit
   typedef struct packed {
      logic in_frame;
      logic [4:0] ones;
      logic [6:0] bitcnt;
      logic [4:0] pos;
      logic err;
      logic pend;
      logic [15:0] id;
      logic [`DCSP_HIST_BITS-1:0] hist;
      dcsp_out_mode_t mode;
      logic [6:0] pc;
      logic [`DCSP_PAY_BITS-1:0] ins;
      logic done;
      dcsp_frame_t frm;
      logic ob;
   } dcsp_link_t;

endpackage

// ### testbench/dcsp_chained_serial_port_props.sv
// dcsp_chained_serial_port_props: port-level assertions for the chained serial port
// assumes: bound to the port module; all checks run in the system clock domain
`timescale 1ns/1ps
`default_nettype none

module dcsp_chained_serial_port_props (
   input wire logic clock,
   input wire logic rstn,
   input wire logic undervoltage_flag,
   input wire logic thermal_entry,
   input wire logic ref_short_entry,
   input wire logic cfg_write_valid,
   input wire dcsp_pkg::dcsp_frame_t cfg_write,
   input wire logic display_write_valid,
   input wire dcsp_pkg::dcsp_frame_t display_write,
   input wire logic frame_sync,
   input wire logic soft_reset,
   input wire logic [4:0] chip_addr,
   input wire logic [4:0] chip_count_m1,
   input wire logic power_save,
   input wire logic channels_off
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);

   // flags held long enough to pass the two-flop synchronisers; power save output held two cycles
   sequence s_uv_held; undervoltage_flag [*4]; endsequence
   sequence s_hot_held; thermal_entry [*4]; endsequence
   sequence s_short_held; ref_short_entry [*4]; endsequence
   sequence s_ps_held; power_save [*2]; endsequence

   property p_uv_reset;
      s_uv_held |-> chip_addr == 5'h00 && chip_count_m1 == 5'h07 && !frame_sync;
   endproperty
   a_uv_reset: assert property (p_uv_reset) else $error("undervoltage did not reset");
   property p_hot_off; s_hot_held |-> channels_off; endproperty
   a_hot_off: assert property (p_hot_off) else $error("thermal left channels on");
   property p_short_off; s_short_held |-> channels_off; endproperty
   a_short_off: assert property (p_short_off) else $error("ref short left channels on");
   property p_ps_off; s_ps_held |-> channels_off; endproperty
   a_ps_off: assert property (p_ps_off) else $error("power save left channels on");
   property p_cfg_count;
      cfg_write_valid && cfg_write.id == 16'haa00 |-> ##[0:2] chip_count_m1 == cfg_write.data[4:0];
   endproperty
   a_cfg_count: assert property (p_cfg_count) else $error("chain length not taken");
   property p_srst;
      soft_reset |-> ##[0:2] chip_count_m1 == 5'h07 && chip_addr == 5'h00;
   endproperty
   a_srst: assert property (p_srst) else $error("soft reset kept registers");
   property p_gray_exit; display_write_valid && |display_write.data |-> ##[0:2] !power_save;
   endproperty
   a_gray_exit: assert property (p_gray_exit) else $error("power save not left");
   property p_cfg_pulse; cfg_write_valid |=> !cfg_write_valid; endproperty
   a_cfg_pulse: assert property (p_cfg_pulse) else $error("write strobe too long");
   property p_srst_alone; soft_reset |-> !cfg_write_valid && !display_write_valid; endproperty
   a_srst_alone: assert property (p_srst_alone) else $error("reset frame also wrote");
endmodule

bind dcsp_chained_serial_port dcsp_chained_serial_port_props u_dcsp_chained_serial_port_props (
   .clock(clock), .rstn(rstn), .undervoltage_flag(undervoltage_flag),
   .thermal_entry(thermal_entry), .ref_short_entry(ref_short_entry),
   .cfg_write_valid(cfg_write_valid), .cfg_write(cfg_write),
   .display_write_valid(display_write_valid), .display_write(display_write),
   .frame_sync(frame_sync), .soft_reset(soft_reset), .chip_addr(chip_addr),
   .chip_count_m1(chip_count_m1), .power_save(power_save), .channels_off(channels_off));
`default_nettype wire

// ### testbench/dcsp_ctrl_model.sv
// dcsp_ctrl_model: controller at the chain head, sends frames and records serial_out
// assumes: serial_clock made by the bench and running free
`timescale 1ns/1ps
`default_nettype none

module dcsp_ctrl_model (
   input wire logic serial_clock,
   output logic serial_in,
   input wire logic serial_out
);
   logic rx_on;
   logic rx [$];

   // line idles high between frames, clock keeps running
   initial begin
      serial_in = 1'b1;
      rx_on = 1'b0;
   end

   // sample the output mid-half, away from both edges where it changes
   always @(serial_clock) begin
      #1.5;
      if (rx_on) rx.push_back(serial_out);
   end

   // word: 16 bits msb first, check bit inverse of the last unless bad
   function automatic void add_word(ref logic q[$], input logic [15:0] v, input logic bad);
      for (int i = 15; i >= 0; i--) q.push_back(v[i]);
      q.push_back(bad ? v[0] : ~v[0]);
   endfunction

   // start, header, blue green red words, then ones to end
   task automatic send(input logic [15:0] id, input logic [47:0] d, input int nw,
                       input logic bad);
      logic q[$];
      q.push_back(1'b0);
      add_word(q, id, 1'b0);
      for (int n = 0; n < nw; n++) begin
         add_word(q, d[47:32], 1'b0);
         add_word(q, d[31:16], 1'b0);
         add_word(q, d[15:0], bad);
      end
      repeat (20) q.push_back(1'b1);
      @(posedge serial_clock);
      // one bit per edge, so each sampling edge sees a settled level
      foreach (q[i]) begin
         @(serial_clock);
         serial_in <= q[i];
      end
   endtask
endmodule
`default_nettype wire

// ### testbench/dcsp_chained_serial_port_tb.sv
// dcsp_chained_serial_port_tb: self-checking bench, one device at the chain head
// assumes: package, port module, checker and controller model compiled first
`timescale 1ns/1ps
`default_nettype none

module dcsp_chained_serial_port_tb;
   logic clock, rstn, serial_clock, serial_in, serial_out;
   logic undervoltage_flag, thermal_entry, ref_short_entry;
   logic [47:0] read_data;
   logic cfg_write_valid, display_write_valid, frame_sync, soft_reset;
   dcsp_pkg::dcsp_frame_t cfg_write, display_write;
   logic [4:0] chip_addr, chip_count_m1;
   logic power_save, channels_off;
   logic [3:0] seen;
   int n_tests, n_mismatch, dly;

   dcsp_chained_serial_port u_dcsp_chained_serial_port (
      .clock(clock), .rstn(rstn), .serial_clock(serial_clock), .serial_in(serial_in),
      .serial_out(serial_out), .undervoltage_flag(undervoltage_flag),
      .thermal_entry(thermal_entry), .ref_short_entry(ref_short_entry),
      .read_data(read_data), .cfg_write_valid(cfg_write_valid), .cfg_write(cfg_write),
      .display_write_valid(display_write_valid), .display_write(display_write),
      .frame_sync(frame_sync), .soft_reset(soft_reset), .chip_addr(chip_addr),
      .chip_count_m1(chip_count_m1), .power_save(power_save), .channels_off(channels_off));
   dcsp_ctrl_model u_dcsp_ctrl_model (
      .serial_clock(serial_clock), .serial_in(serial_in), .serial_out(serial_out));

   // system clock 50 ns; link clock 6 ns, offset so the two never line up
   always #25 clock = ~clock;
   initial begin
      serial_clock = 1'b0;
      #1.3;
      forever #3 serial_clock = ~serial_clock;
   end

   // sticky pulse catcher, cleared before each frame
   always @(posedge clock) begin
      seen <= seen | {soft_reset, frame_sync, display_write_valid, cfg_write_valid};
   end

   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // bounded wait for a caught pulse; gives up into the closing report
   task automatic wait_ev(input int k, input string nm);
      for (dly = 0; dly < 400 && !seen[k]; dly++) @(negedge clock);
      chk(nm, 64'h1, 64'(seen[k]));
      if (!seen[k]) end_sim();
   endtask

   task automatic go(input logic [15:0] id, input logic [47:0] d, input int nw, input logic bad);
      @(negedge clock);
      seen = 4'h0;
      u_dcsp_ctrl_model.send(id, d, nw, bad);
   endtask

   // bits of the first frame seen on serial_out, counted from its start bit
   function automatic logic [63:0] rx_bits(input int a, input int n);
      int i;
      logic [63:0] v;
      i = 0;
      v = 64'h0;
      while (i < 300 && u_dcsp_ctrl_model.rx[i] !== 1'b0) i++;
      for (int b = a; b < a + n; b++) v = {v[62:0], u_dcsp_ctrl_model.rx[i + b]};
      return v;
   endfunction

   task automatic t_index();
      u_dcsp_ctrl_model.rx_on = 1'b1;
      go(16'haa13, 48'h0, 0, 1'b0);
      repeat (20) @(negedge clock);
      chk("chip_addr", 64'h3, 64'(chip_addr));
      chk("fwd header", 64'haa14, rx_bits(1, 16));
      chk("fwd check", 64'h1, rx_bits(17, 1));
      $display("test index done");
   endtask

   task automatic t_cfg();
      u_dcsp_ctrl_model.rx.delete();
      go(16'haa00, 48'h00a5_0000_1004, 1, 1'b0);
      wait_ev(0, "cfg_write_valid");
      chk("cfg_write", {16'haa00, 48'h00a5_0000_1004}, cfg_write);
      repeat (3) @(negedge clock);
      chk("chip_count_m1", 64'h4, 64'(chip_count_m1));
      chk("fwd payload", 64'h0000_0528_0002_2009, rx_bits(18, 51));
      go(16'haa00, 48'h1002, 1, 1'b1);
      repeat (30) @(negedge clock);
      chk("bad frame strobe", 64'h0, 64'(seen[0]));
      chk("chip_count_m1", 64'h4, 64'(chip_count_m1));
      $display("test config done");
   endtask

   // count 4 and address 3 give two hops of five cycles, plus the crossing
   task automatic t_sync();
      go(16'haaf0, 48'h0, 0, 1'b0);
      wait_ev(2, "frame_sync");
      chk("sync delay", 64'h1, 64'(dly >= 10 && dly <= 16));
      repeat (2) @(negedge clock);
      chk("power_save", 64'h1, 64'(power_save));
      chk("channels_off", 64'h1, 64'(channels_off));
      u_dcsp_ctrl_model.rx.delete();
      go(16'haa30, 48'h0001_0002_0003, 1, 1'b0);
      wait_ev(1, "display_write_valid");
      chk("display_write", {16'haa30, 48'h0001_0002_0003}, display_write);
      repeat (3) @(negedge clock);
      chk("power_save", 64'h0, 64'(power_save));
      chk("cut payload", 64'h0007_ffff_ffff_ffff, rx_bits(18, 51));
      $display("test sync and power save done");
   endtask

   task automatic t_prot();
      for (int k = 0; k < 2; k++) begin
         @(posedge clock);
         {ref_short_entry, thermal_entry} <= 2'(1 << k);
         repeat (6) @(negedge clock);
         chk("channels_off", 64'h1, 64'(channels_off));
         @(posedge clock);
         {ref_short_entry, thermal_entry} <= 2'h0;
         repeat (6) @(negedge clock);
         chk("channels_off", 64'h0, 64'(channels_off));
      end
      $display("test protection done");
   endtask

   // read: own words with fresh check bits follow the forwarded header
   task automatic t_read();
      @(posedge clock);
      read_data <= 48'h8001_4002_2004;
      repeat (20) @(negedge clock);
      u_dcsp_ctrl_model.rx.delete();
      go(16'haa60, 48'h0, 0, 1'b0);
      repeat (20) @(negedge clock);
      chk("read header", 64'haa60, rx_bits(1, 16));
      chk("read data", 64'h0004_0009_000a_4009, rx_bits(18, 51));
      $display("test read done");
   endtask

   task automatic t_reset_paths();
      go(16'haa80, 48'h0, 0, 1'b0);
      wait_ev(3, "soft_reset");
      repeat (3) @(negedge clock);
      chk("chip_count_m1", 64'h7, 64'(chip_count_m1));
      chk("chip_addr", 64'h0, 64'(chip_addr));
      go(16'haa15, 48'h0, 0, 1'b0);
      repeat (20) @(negedge clock);
      chk("chip_addr", 64'h5, 64'(chip_addr));
      @(posedge clock);
      undervoltage_flag <= 1'b1;
      repeat (6) @(negedge clock);
      chk("chip_addr", 64'h0, 64'(chip_addr));
      chk("channels_off", 64'h1, 64'(channels_off));
      @(posedge clock);
      undervoltage_flag <= 1'b0;
      repeat (6) @(negedge clock);
      chk("channels_off", 64'h0, 64'(channels_off));
      $display("test resets done");
   endtask

   initial begin
      clock = 1'b0;
      rstn = 1'b0;
      undervoltage_flag = 1'b0;
      thermal_entry = 1'b0;
      ref_short_entry = 1'b0;
      read_data = 48'h0;
      seen = 4'h0;
      n_tests = 0;
      n_mismatch = 0;
      repeat (12) @(posedge clock);
      rstn <= 1'b1;
      repeat (3) @(negedge clock);
      chk("chip_count_m1", 64'h7, 64'(chip_count_m1));
      chk("serial_out idle", 64'h1, 64'(serial_out));
      t_index();
      t_cfg();
      t_sync();
      t_prot();
      t_read();
      t_reset_paths();
      end_sim();
   end
endmodule
`default_nettype wire
